// File: design/ipb_defs.svh
// Register map, field layout, reset values and decode constants of the priority bank
//
// Contract
// [RULE_01] Priority code 111 is level seven, the highest level a source can have.
// [RULE_02] Priority code 001 is level one, the lowest active level.
// [RULE_03] Priority code 000 disables the source so it never raises a request.
// [RULE_04] Codes 010 to 110 give levels two to six, a larger code always ranking higher.
// [RULE_05] Every bit outside a priority field ignores writes and reads as zero. The status word at 8'h80 reads back its request, level and source bits.
// [RULE_06] Every priority field resets to 100 (level four) and is readable and writable.
// [RULE_07] The I2C-B register holds the master event priority in bits 10 to 8.
// [RULE_08] The I2C-B register holds the slave event priority in bits 6 to 4.
// [RULE_09] The external interrupt register holds the interrupt four priority in bits 10 to 8.
// [RULE_10] The external interrupt register holds the interrupt three priority in bits 6 to 4.
// [RULE_11] The calendar register holds the calendar clock priority in bits 10 to 8.
// [RULE_12] The checksum/serial register holds the checksum error priority in bits 14 to 12.
// [RULE_13] The checksum/serial register holds the serial B error priority in bits 10 to 8.
// [RULE_14] The checksum/serial register holds the serial A error priority in bits 6 to 4.
// [RULE_15] The low-voltage register holds the low-voltage priority in bits 2 to 0.
// [RULE_16] The charge-timer register holds the charge-timer priority in bits 6 to 4.
`ifndef IPB_DEFS_SVH
`define IPB_DEFS_SVH

// Byte offsets of the registers
`define IPB_OFF_I2C2_PRIORITY_CTL        8'h30
`define IPB_OFF_EXT_INT34_PRIORITY_CTL   8'h34
`define IPB_OFF_RTC_PRIORITY_CTL         8'h3c
`define IPB_OFF_CRC_UART_ERR_PRIORITY_CTL 8'h40
`define IPB_OFF_LOW_VOLTAGE_PRIORITY_CTL 8'h48
`define IPB_OFF_CHARGE_TIMER_PRIORITY_CTL 8'h4c
`define IPB_OFF_STATUS                   8'h80

// Lowest bit of each priority field
`define IPB_POS_I2C_B_MASTER     5'd8
`define IPB_POS_I2C_B_SLAVE      5'd4
`define IPB_POS_EXT_IRQ_FOUR     5'd8
`define IPB_POS_EXT_IRQ_THREE    5'd4
`define IPB_POS_CALENDAR_CLOCK   5'd8
`define IPB_POS_CHECKSUM_GEN_ERR 5'd12
`define IPB_POS_SERIAL_B_ERROR   5'd8
`define IPB_POS_SERIAL_A_ERROR   5'd4
`define IPB_POS_LOW_VOLTAGE      5'd0
`define IPB_POS_CHARGE_TIMER     5'd4

// Status register fields
`define IPB_POS_STAT_REQ   5'd0
`define IPB_POS_STAT_LEVEL 5'd16
`define IPB_POS_STAT_SRC   5'd24

// Field reset value and special codes
`define IPB_PRIO_RESET    3'h4
`define IPB_PRIO_DISABLED 3'h0
`define IPB_PRIO_HIGHEST  3'h7
`define IPB_PRIO_LOWEST   3'h1

// Bus decode
`define IPB_ADDR_BITS 8
`define IPB_NUM_SRC   10

`endif

// File: design/ipb_pkg.sv
// Types shared by the priority bank
package ipb_pkg;

    // Interrupt sources, in bank order; lower index wins a tie
    typedef enum logic [3:0] {
        IPB_SRC_I2C_B_MASTER     = 4'h0,
        IPB_SRC_I2C_B_SLAVE      = 4'h1,
        IPB_SRC_EXT_IRQ_FOUR     = 4'h2,
        IPB_SRC_EXT_IRQ_THREE    = 4'h3,
        IPB_SRC_CALENDAR_CLOCK   = 4'h4,
        IPB_SRC_CHECKSUM_GEN_ERR = 4'h5,
        IPB_SRC_SERIAL_B_ERROR   = 4'h6,
        IPB_SRC_SERIAL_A_ERROR   = 4'h7,
        IPB_SRC_LOW_VOLTAGE      = 4'h8,
        IPB_SRC_CHARGE_TIMER     = 4'h9
    } ipb_src_t;

    // Bus slave phase
    typedef enum logic [1:0] {
        IPB_BUS_IDLE    = 2'b00,
        IPB_BUS_RD_WAIT = 2'b01,
        IPB_BUS_RD_DONE = 2'b10
    } ipb_bus_state_t;

    // Three-bit priority code
    typedef logic [2:0] ipb_prio_t;

endpackage : ipb_pkg

// File: design/ipb_top.sv
// Interrupt priority bank: ten 3-bit priority fields behind an AHB-Lite slave
`timescale 1ns/1ns
`default_nettype none
`include "ipb_defs.svh"

module ipb_top
    import ipb_pkg::*;
#(
    parameter int NUM_SRC = `IPB_NUM_SRC
) (
    input  wire logic               i_clk_sys,
    input  wire logic               i_arst_n,
    // AHB-Lite slave
    input  wire logic               i_hsel,
    input  wire logic [31:0]        i_haddr,
    input  wire logic [1:0]         i_htrans,
    input  wire logic               i_hwrite,
    input  wire logic [2:0]         i_hsize,
    input  wire logic [31:0]        i_hwdata,
    input  wire logic               i_hready,
    output var  logic [31:0]        o_hrdata,
    output var  logic               o_hreadyout,
    output var  logic               o_hresp,
    // Raw requests from the sources, same clock
    input  wire logic [NUM_SRC-1:0] i_src_req,
    // Requests that survive their priority code
    output var  logic [NUM_SRC-1:0] o_req_gated,
    // All ten priority codes, three bits per source
    output var  logic [3*NUM_SRC-1:0] o_src_prio,
    // Winning request level and source
    output var  logic [2:0]         o_top_level,
    output var  logic [3:0]         o_top_src
);

    localparam int AW = `IPB_ADDR_BITS;

    // Offset of the read-only status word
    localparam logic [AW-1:0] STAT_OFF = `IPB_OFF_STATUS;

    // Register offset of each source's field
    localparam logic [AW-1:0] SRC_OFF [NUM_SRC] = '{
        `IPB_OFF_I2C2_PRIORITY_CTL,          // [RULE_07]
        `IPB_OFF_I2C2_PRIORITY_CTL,          // [RULE_08]
        `IPB_OFF_EXT_INT34_PRIORITY_CTL,     // [RULE_09]
        `IPB_OFF_EXT_INT34_PRIORITY_CTL,     // [RULE_10]
        `IPB_OFF_RTC_PRIORITY_CTL,           // [RULE_11]
        `IPB_OFF_CRC_UART_ERR_PRIORITY_CTL,  // [RULE_12]
        `IPB_OFF_CRC_UART_ERR_PRIORITY_CTL,  // [RULE_13]
        `IPB_OFF_CRC_UART_ERR_PRIORITY_CTL,  // [RULE_14]
        `IPB_OFF_LOW_VOLTAGE_PRIORITY_CTL,   // [RULE_15]
        `IPB_OFF_CHARGE_TIMER_PRIORITY_CTL   // [RULE_16]
    };

    // Lowest bit of each source's field
    localparam logic [4:0] SRC_POS [NUM_SRC] = '{
        `IPB_POS_I2C_B_MASTER,      // [RULE_07]
        `IPB_POS_I2C_B_SLAVE,       // [RULE_08]
        `IPB_POS_EXT_IRQ_FOUR,      // [RULE_09]
        `IPB_POS_EXT_IRQ_THREE,     // [RULE_10]
        `IPB_POS_CALENDAR_CLOCK,    // [RULE_11]
        `IPB_POS_CHECKSUM_GEN_ERR,  // [RULE_12]
        `IPB_POS_SERIAL_B_ERROR,    // [RULE_13]
        `IPB_POS_SERIAL_A_ERROR,    // [RULE_14]
        `IPB_POS_LOW_VOLTAGE,       // [RULE_15]
        `IPB_POS_CHARGE_TIMER       // [RULE_16]
    };

    // Bus phase state
    ipb_bus_state_t          bus_state_q;
    ipb_bus_state_t          bus_state_d;

    // Captured address phase
    logic                    wr_pend_q;
    logic                    rd_pend_q;
    logic [AW-1:0]           addr_q;
    logic [2:0]              size_q;
    logic                    addr_take;

    // Byte lanes enabled by the captured transfer
    logic [3:0]              lane_en;

    // Priority storage
    ipb_prio_t               prio_q [NUM_SRC];

    // Gated requests and winner
    logic [NUM_SRC-1:0]      req_gated;
    logic [2:0]              top_level;
    logic [3:0]              top_src;

    // Read data assembled from the captured address
    logic [31:0]             rd_word;
    logic                    hreadyout_q;
    logic [31:0]             hrdata_q;
    logic [NUM_SRC-1:0]      req_gated_q;
    logic [2:0]              top_level_q;
    logic [3:0]              top_src_q;

    // Address phase accepted on an active transfer while the bus is ready
    assign addr_take = i_hsel && i_htrans[1] && i_hready;

    // Byte lanes from size and low address bits
    always_comb begin
        lane_en = 4'h0;
        case (size_q)
            3'h0: begin
                lane_en[addr_q[1:0]] = 1'b1;
            end
            3'h1: begin
                if (addr_q[1]) begin
                    lane_en = 4'hc;
                end else begin
                    lane_en = 4'h3;
                end
            end
            default: begin
                lane_en = 4'hf;
            end
        endcase
    end

    // Capture of the address phase
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            addr_q    <= '0;
            size_q    <= 3'h0;
        end else if (i_hready) begin
            wr_pend_q <= addr_take && i_hwrite;
            rd_pend_q <= addr_take && !i_hwrite;
            if (addr_take) begin
                addr_q <= i_haddr[AW-1:0];
                size_q <= i_hsize;
            end
        end else begin
            rd_pend_q <= 1'b0;
        end
    end

    // Reads take one wait state so a write just before is seen
    always_comb begin
        bus_state_d = bus_state_q;
        case (bus_state_q)
            IPB_BUS_IDLE: begin
                if (addr_take && !i_hwrite) begin
                    bus_state_d = IPB_BUS_RD_WAIT;
                end
            end
            IPB_BUS_RD_WAIT: begin
                bus_state_d = IPB_BUS_RD_DONE;
            end
            IPB_BUS_RD_DONE: begin
                if (addr_take && !i_hwrite) begin
                    bus_state_d = IPB_BUS_RD_WAIT;
                end else begin
                    bus_state_d = IPB_BUS_IDLE;
                end
            end
            default: begin
                bus_state_d = IPB_BUS_IDLE;
            end
        endcase
    end

    // Bus state register
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            bus_state_q <= IPB_BUS_IDLE;
        end else begin
            bus_state_q <= bus_state_d;
        end
    end

    // Ready drops for exactly the wait cycle of a read
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            hreadyout_q <= 1'b1;
        end else begin
            hreadyout_q <= (bus_state_d != IPB_BUS_RD_WAIT);
        end
    end

    // Field writes; bits outside fields have no storage
    generate
        for (genvar s = 0; s < NUM_SRC; s++) begin : g_field
            always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
                if (!i_arst_n) begin
                    prio_q[s] <= `IPB_PRIO_RESET;  // [RULE_06]
                end else if (wr_pend_q && (addr_q[AW-1:2] == SRC_OFF[s][AW-1:2])
                             && lane_en[SRC_POS[s][4:3]]) begin
                    prio_q[s] <= i_hwdata[SRC_POS[s] +: 3];  // [RULE_06]
                end
            end
        end
    endgenerate

    // Code 000 blocks a source; any other code lets it through
    always_comb begin
        for (int s = 0; s < NUM_SRC; s++) begin
            req_gated[s] = i_src_req[s] && (prio_q[s] != `IPB_PRIO_DISABLED);  // [RULE_03]
        end
    end

    // Highest code wins; code is the level itself, 001 lowest to 111 highest
    always_comb begin
        top_level = `IPB_PRIO_DISABLED;
        top_src   = 4'h0;
        for (int s = 0; s < NUM_SRC; s++) begin
            if (req_gated[s] && (prio_q[s] > top_level)) begin  // [RULE_01] [RULE_02] [RULE_04]
                top_level = prio_q[s];
                top_src   = 4'(s);
            end
        end
    end

    // Read word of the captured address; unassigned bits stay zero
    always_comb begin
        rd_word = 32'h0;
        for (int s = 0; s < NUM_SRC; s++) begin
            if (addr_q[AW-1:2] == SRC_OFF[s][AW-1:2]) begin
                rd_word[SRC_POS[s] +: 3] = prio_q[s];  // [RULE_05]
            end
        end
        if (addr_q[AW-1:2] == STAT_OFF[AW-1:2]) begin
            rd_word[`IPB_POS_STAT_REQ   +: NUM_SRC] = req_gated_q;
            rd_word[`IPB_POS_STAT_LEVEL +: 3]       = top_level_q;
            rd_word[`IPB_POS_STAT_SRC   +: 4]       = top_src_q;
        end
    end

    // Read data loaded in the wait cycle, zero otherwise
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            hrdata_q <= 32'h0;
        end else if (bus_state_q == IPB_BUS_RD_WAIT) begin
            hrdata_q <= rd_word;  // [RULE_05]
        end else if (bus_state_q == IPB_BUS_RD_DONE) begin
            hrdata_q <= 32'h0;
        end
    end

    // Registered request view
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            req_gated_q <= '0;
            top_level_q <= `IPB_PRIO_DISABLED;
            top_src_q   <= 4'h0;
        end else begin
            req_gated_q <= req_gated;  // [RULE_03]
            top_level_q <= top_level;
            top_src_q   <= top_src;
        end
    end

    // Priority codes out
    always_comb begin
        for (int s = 0; s < NUM_SRC; s++) begin
            o_src_prio[3*s +: 3] = prio_q[s];
        end
    end

    // Ports
    assign o_hrdata    = hrdata_q;
    assign o_hreadyout = hreadyout_q;
    assign o_hresp     = 1'b0;
    assign o_req_gated = req_gated_q;
    assign o_top_level = top_level_q;
    assign o_top_src   = top_src_q;

endmodule : ipb_top
`default_nettype wire

// File: test/ipb_properties.sv
// Port-level checker for the priority bank
`timescale 1ns/1ns
`default_nettype none
module ipb_checker
    import ipb_pkg::*;
#(
    parameter int NUM_SRC = 10
) (
    input wire logic                   i_clk_sys,
    input wire logic                   i_arst_n,
    input wire logic                   i_hsel,
    input wire logic [1:0]             i_htrans,
    input wire logic                   i_hwrite,
    input wire logic                   i_hready,
    input wire logic [31:0]            o_hrdata,
    input wire logic                   o_hreadyout,
    input wire logic [NUM_SRC-1:0]     i_src_req,
    input wire logic [NUM_SRC-1:0]     o_req_gated,
    input wire logic [3*NUM_SRC-1:0]   o_src_prio,
    input wire logic [2:0]             o_top_level,
    input wire logic [3:0]             o_top_src
);
    logic [NUM_SRC-1:0] src_en;
    logic [NUM_SRC-1:0] req_en;
    logic               take;
    logic               wr_ph_q;

    // Sources whose code is nonzero
    always_comb begin
        for (int s = 0; s < NUM_SRC; s++) begin
            src_en[s] = |o_src_prio[3*s +: 3];
        end
    end
    assign req_en = i_src_req & src_en;
    assign take   = i_hsel & i_htrans[1] & i_hready;

    // Marks the data phase of a write
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            wr_ph_q <= 1'b0;
        end else begin
            wr_ph_q <= take & i_hwrite;
        end
    end

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_arst_n);

    sequence s_rd_wait;
        ##1 !o_hreadyout ##1 o_hreadyout;
    endsequence

    AST_READ_WAIT: assert property (take && !i_hwrite |-> s_rd_wait)
        else $error("read wait state wrong");
    AST_WRITE_NOWAIT: assert property (take && i_hwrite |=> o_hreadyout)
        else $error("write stalled");
    AST_GATED: assert property ($past(i_arst_n) |-> o_req_gated == $past(req_en))
        else $error("gated requests wrong");
    AST_TOP_ZERO: assert property (o_req_gated == '0 |-> o_top_level == 3'h0)
        else $error("level without request");
    AST_TOP_SRC: assert property (o_top_level != 3'h0 |-> o_req_gated[o_top_src])
        else $error("winner not requesting");
    AST_RSVD_ZERO: assert property (o_hrdata[15] == 1'b0 && o_hrdata[11] == 1'b0)
        else $error("unused bit set");
    AST_PRIO_RESET: assert property ($rose(i_arst_n) |-> o_src_prio == {NUM_SRC{3'h4}})
        else $error("field reset value wrong");
    AST_PRIO_HOLD: assert property (!$past(wr_ph_q) |-> $stable(o_src_prio))
        else $error("field changed without write");
endmodule : ipb_checker

bind ipb_top ipb_checker #(.NUM_SRC(NUM_SRC)) u_ipb_checker (
    .i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_hsel(i_hsel), .i_htrans(i_htrans),
    .i_hwrite(i_hwrite), .i_hready(i_hready), .o_hrdata(o_hrdata),
    .o_hreadyout(o_hreadyout), .i_src_req(i_src_req), .o_req_gated(o_req_gated),
    .o_src_prio(o_src_prio), .o_top_level(o_top_level), .o_top_src(o_top_src)
);
`default_nettype wire

// File: test/tb_top.sv
// Self-checking bench for the priority bank
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import ipb_pkg::*;
    logic        clk;
    logic        arst_n;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hrdy;
    logic        hresp;
    logic [9:0]  req;
    logic [9:0]  gated;
    logic [29:0] prio;
    logic [29:0] ep;
    logic [2:0]  lvl;
    logic [3:0]  src;
    logic [31:0] rd;
    int          n_errors;
    int          tests_run;
    int          cyc;
    // Address, write data, read-back value
    logic [95:0] rows [13] = '{
        {32'h30, 32'hffffffff, 32'h0770}, {32'h34, 32'hffffffff, 32'h0770},
        {32'h3c, 32'hffffffff, 32'h0700}, {32'h40, 32'hffffffff, 32'h7770},
        {32'h48, 32'hffffffff, 32'h0007}, {32'h4c, 32'hffffffff, 32'h0070},
        {32'h44, 32'hffffffff, 32'h0}, {32'h30, 32'h0710, 32'h0710},
        {32'h34, 32'h0230, 32'h0230}, {32'h3c, 32'h0500, 32'h0500},
        {32'h40, 32'h6000, 32'h6000}, {32'h48, 32'h0004, 32'h0004},
        {32'h4c, 32'h0, 32'h0}};
    logic [31:0] rst_v [7] = '{32'h0440, 32'h0440, 32'h0400, 32'h4440, 32'h4, 32'h40, 32'h0};
    logic [2:0]  code [10] = '{3'h7, 3'h1, 3'h2, 3'h3, 3'h5, 3'h6, 3'h0, 3'h0, 3'h4, 3'h0};

    ipb_top u_ipb_top (
        .i_clk_sys(clk), .i_arst_n(arst_n), .i_hsel(hsel), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
        .i_hready(hrdy), .o_hrdata(hrdata), .o_hreadyout(hrdy), .o_hresp(hresp),
        .i_src_req(req), .o_req_gated(gated), .o_src_prio(prio),
        .o_top_level(lvl), .o_top_src(src)
    );

    // Clock at 4 ns
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Verdict and end of run
    task automatic end_of_test();
        $display("errors %0d checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_of_test

    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %h vs %h", $time, got, exp);
        end
    endtask : chk

    // Wait for the rising edge at which ready is sampled high; take read data there
    task automatic wait_rdy();
        do @(posedge clk); while (hrdy !== 1'b1);
        rd = hrdata;
    endtask : wait_rdy

    // One single-word transfer, entered just after an edge
    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'b10;
        hwrite <= wr;
        wait_rdy();
        htrans <= 2'b00;
        hwdata <= d;
        wait_rdy();
    endtask : xfer

    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc > 2000) begin
            n_errors++;
            end_of_test();
        end
    end

    // Main sequence
    initial begin
        {hsel, haddr, htrans, hwrite, hwdata, req, arst_n} = '0;
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            xfer(1'b0, rows[i][95:64], 32'h0);
            chk(rd, rst_v[i]);
        end
        foreach (rows[i]) begin
            xfer(1'b1, rows[i][95:64], rows[i][63:32]);
            xfer(1'b0, rows[i][95:64], 32'h0);
            chk(rd, rows[i][31:0]);
        end
        for (int s = 0; s < 10; s++) ep[3*s +: 3] = code[s];
        chk(32'(prio), 32'(ep));
        // Each source alone
        for (int s = 0; s < 10; s++) begin
            req <= 10'h1 << s;
            @(posedge clk);
            @(negedge clk);
            chk(32'(gated), 32'((10'h1 << s) & 10'h13f));
            chk(32'(lvl), 32'(code[s]));
            chk(32'(src), (code[s] != 3'h0) ? 32'(s) : 32'h0);
            @(posedge clk);
        end
        req <= 10'h3ff;
        @(posedge clk);
        @(negedge clk);
        chk(32'(lvl), 32'h7);
        @(posedge clk);
        xfer(1'b0, 32'h80, 32'h0);
        chk(rd, 32'h0007013f);
        chk(32'(hresp), 32'h0);
        xfer(1'b1, 32'h30, 32'h10);
        @(posedge clk);
        @(negedge clk);
        chk(32'(gated), 32'h13e);
        chk({lvl, src}, 32'h65);
        // Reset in mid-run
        @(posedge clk);
        arst_n <= 1'b0;
        @(negedge clk);
        chk(32'(prio), 32'h24924924);
        chk(32'(gated), 32'h0);
        @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        @(negedge clk);
        chk(32'(gated), 32'h3ff);
        chk({lvl, src}, 32'h40);
        end_of_test();
    end
endmodule : tb_top
`default_nettype wire
